// file: rtl/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
module pin_sync3 (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Pin and filtered level
    input  wire logic pin,
    output      logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_t;

    sync_t sync_q;
    sync_t sync_d;

    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    // Only the second stage reads the first; a level counts once the last two agree
    always_comb begin
        sync_d    = sync_q;
        sync_d.s1 = pin;
        sync_d.s2 = sync_q.s1;
        sync_d.s3 = sync_q.s2;
        if (sync_q.s2 == sync_q.s3) begin
            sync_d.level = sync_q.s3;
        end
    end

    // Idle bus level is high, so reset to released
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync_q <= '1;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign level = sync_q.level;
endmodule // pin_sync3

// file: rtl/trim_regs.sv
// Address and output-current trim registers behind a byte-wide two-wire target
module trim_regs (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    // Two-wire management bus pins
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output      logic                          sda_out,
    output      logic                          sda_oe_n,
    // Power-up sources
    input  wire logic [6:0]                    strap_address,
    input  wire trim_regs_pkg::nvm_image_t     nvm_image,
    // Current telemetry
    input  wire trim_regs_pkg::current_sample_t current_monitor,
    input  wire logic [7:0]                    full_scale_current_limit,
    output      logic [7:0]                    output_current_reading,
    output      logic                          output_current_valid,
    // Addresses in force
    output      logic [6:0]                    bus_address_active,
    output      logic [3:0]                    vid_bus_address
);
    import trim_regs_pkg::*;

    state_t s_q;
    state_t s_d;
    logic   scl_s;
    logic   sda_s;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pin_sync3 u_scl_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pin     (scl_in),
        .level   (scl_s)
    );

    pin_sync3 u_sda_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pin     (sda_in),
        .level   (sda_s)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] read_mux(input state_t s, input logic [7:0] ofs);
        logic [7:0] r;
        r = UNMAPPED_READ;
        unique case (ofs)
            BUS_TARGET_ADDRESS_OFS:  r = {1'b0, s.override ? s.addr_field : s.strap};
            VID_BUS_ADDRESS_OFS:     r = {4'h0, s.vid_addr};
            OUTPUT_CURRENT_TRIM_OFS: r = s.trim;
            default:                 r = UNMAPPED_READ;
        endcase
        return r;
    endfunction

    // Signed offset in quarter amps
    function automatic logic signed [5:0] offset_quarters(input logic [3:0] code);
        logic signed [5:0] q;
        if (code >= OFFSET_POS_FIRST) begin
            q = $signed({2'b00, code}) - $signed({1'b0, OFFSET_POS_BIAS});
        end else begin
            q = $signed({2'b00, code}) - $signed({1'b0, OFFSET_NEG_BIAS});
        end
        return q;
    endfunction

    // Corrected reading in amps from a raw sample
    function automatic logic [7:0] corrected(input logic [9:0] raw, input logic [7:0] trim,
                                             input logic [7:0] limit);
        logic [17:0]        prod;
        logic [17:0]        scaled;
        logic signed [12:0] sum;
        prod   = 18'(raw) * 18'(GAIN_BASE + 8'(trim[GAIN_MSB:GAIN_LSB]));
        scaled = prod / 18'(GAIN_DIV);
        sum    = $signed({1'b0, scaled[11:0]}) + 13'(offset_quarters(trim[OFFSET_MSB:OFFSET_LSB]));
        if (sum < 0) begin
            sum = sum + $signed({3'b000, limit, 2'b00});
        end
        return sum[9:2];
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_cond;
        logic stop_cond;
        logic [7:0] shin;
        logic [7:0] rd;
        s_d        = s_q;
        scl_rise   = scl_s & ~s_q.scl_prev;
        scl_fall   = ~scl_s & s_q.scl_prev;
        start_cond = scl_s & s_q.scl_prev & s_q.sda_prev & ~sda_s;
        stop_cond  = scl_s & s_q.scl_prev & ~s_q.sda_prev & sda_s;
        shin       = {s_q.shift[6:0], sda_s};
        rd         = read_mux(s_q, s_q.ptr);
        s_d.scl_prev      = scl_s;
        s_d.sda_prev      = sda_s;
        s_d.reading_valid = 1'b0;

        // Trim is applied to every new sample with the values in force now
        if (current_monitor.valid) begin
            s_d.reading       = corrected(current_monitor.quarters, s_q.trim, full_scale_current_limit);
            s_d.reading_valid = 1'b1;
        end

        if (start_cond) begin
            s_d.st       = BUS_ADDR;
            s_d.bitcnt   = BITCNT_RESET;
            s_d.sda_oe_n = 1'b1;
        end else if (stop_cond) begin
            s_d.st       = BUS_IDLE;
            s_d.sda_oe_n = 1'b1;
        end else begin
            unique case (s_q.st)
                BUS_IDLE: begin
                    s_d.sda_oe_n = 1'b1;
                end
                BUS_ADDR, BUS_CMD, BUS_WDATA: begin
                    if (scl_rise) begin
                        s_d.shift  = shin;
                        s_d.bitcnt = s_q.bitcnt + 4'h1;
                    end else if (scl_fall && s_q.bitcnt == BITS_PER_BYTE) begin
                        s_d.sda_oe_n = 1'b0;
                        if (s_q.st == BUS_ADDR) begin
                            // Matching uses the address fixed at supply reset
                            if (s_q.shift[7:1] == s_q.active_addr) begin
                                s_d.rw = s_q.shift[0];
                                s_d.st = BUS_ACK_ADDR;
                            end else begin
                                s_d.sda_oe_n = 1'b1;
                                s_d.st       = BUS_IDLE;
                            end
                        end else if (s_q.st == BUS_CMD) begin
                            s_d.ptr = s_q.shift;
                            s_d.st  = BUS_ACK_CMD;
                        end else begin
                            s_d.st = BUS_ACK_DATA;
                            unique case (s_q.ptr)
                                BUS_TARGET_ADDRESS_OFS: begin
                                    s_d.addr_field = s_q.shift[6:0];
                                end
                                VID_BUS_ADDRESS_OFS: begin
                                    if (s_q.shift[3:0] <= VID_ADDR_LAST) begin
                                        s_d.vid_addr = s_q.shift[3:0];
                                    end
                                end
                                OUTPUT_CURRENT_TRIM_OFS: begin
                                    s_d.trim = s_q.shift;
                                end
                                default: begin
                                    s_d.trim = s_q.trim;
                                end
                            endcase
                        end
                    end
                end
                BUS_ACK_ADDR, BUS_ACK_CMD, BUS_ACK_DATA: begin
                    if (scl_fall) begin
                        s_d.bitcnt   = BITCNT_RESET;
                        s_d.sda_oe_n = 1'b1;
                        if (s_q.st == BUS_ACK_ADDR && s_q.rw) begin
                            s_d.shift    = rd;
                            s_d.sda_oe_n = rd[7];
                            s_d.st       = BUS_RDATA;
                        end else if (s_q.st == BUS_ACK_ADDR) begin
                            s_d.st = BUS_CMD;
                        end else begin
                            s_d.st = BUS_WDATA;
                        end
                    end
                end
                BUS_RDATA: begin
                    if (scl_fall) begin
                        s_d.bitcnt = s_q.bitcnt + 4'h1;
                        if (s_q.bitcnt == BITS_PER_BYTE - 4'h1) begin
                            s_d.sda_oe_n = 1'b1;
                            s_d.st       = BUS_RACK;
                        end else begin
                            s_d.shift    = {s_q.shift[6:0], 1'b0};
                            s_d.sda_oe_n = s_q.shift[6];
                        end
                    end
                end
                BUS_RACK: begin
                    if (scl_rise) begin
                        s_d.master_ack = ~sda_s;
                    end else if (scl_fall) begin
                        s_d.bitcnt = BITCNT_RESET;
                        if (s_q.master_ack) begin
                            s_d.shift    = rd;
                            s_d.sda_oe_n = rd[7];
                            s_d.st       = BUS_RDATA;
                        end else begin
                            s_d.st = BUS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register; supply reset reloads the stored image
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q               <= '0;
            s_q.st            <= BUS_IDLE;
            s_q.scl_prev      <= 1'b1;
            s_q.sda_prev      <= 1'b1;
            s_q.sda_oe_n      <= 1'b1;
            s_q.override      <= nvm_image.address_source_override;
            s_q.strap         <= strap_address;
            s_q.addr_field    <= nvm_image.address_source_override ? nvm_image.bus_target_address
                                                                   : strap_address;
            // Address in force is frozen here and only a later reset can change it
            s_q.active_addr   <= nvm_image.address_source_override ? nvm_image.bus_target_address
                                                                   : strap_address;
            s_q.vid_addr      <= nvm_image.vid_bus_address;
            s_q.trim          <= nvm_image.output_current_trim;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sda_out                = 1'b0;
    assign sda_oe_n               = s_q.sda_oe_n;
    assign output_current_reading = s_q.reading;
    assign output_current_valid   = s_q.reading_valid;
    assign bus_address_active     = s_q.active_addr;
    assign vid_bus_address        = s_q.vid_addr;
endmodule // trim_regs

// file: rtl/trim_regs_pkg.sv
// Package: offsets, field positions and fixed values, types and bit-counter constants for the trim register bank
package trim_regs_pkg;

    // ------------------------------------------------------------
    // Register offsets (command codes on the management bus)
    // ------------------------------------------------------------
    localparam logic [7:0] BUS_TARGET_ADDRESS_OFS  = 8'hA2;
    localparam logic [7:0] VID_BUS_ADDRESS_OFS     = 8'hA3;
    localparam logic [7:0] OUTPUT_CURRENT_TRIM_OFS = 8'hA4;

    // ------------------------------------------------------------
    // Field positions and fixed values
    // ------------------------------------------------------------
    localparam int         GAIN_MSB          = 7;
    localparam int         GAIN_LSB          = 4;
    localparam int         OFFSET_MSB        = 3;
    localparam int         OFFSET_LSB        = 0;
    localparam logic [3:0] VID_ADDR_LAST     = 4'hD;
    localparam logic [7:0] UNMAPPED_READ     = 8'h00;
    // Gain factor is (GAIN_BASE + code) / GAIN_DIV: code 0 -> -3.5 %, step 0.5 %
    localparam logic [7:0] GAIN_BASE         = 8'hC1;
    localparam logic [7:0] GAIN_DIV          = 8'hC8;
    // Offset codes: positive side starts at 1000b
    localparam logic [3:0] OFFSET_POS_FIRST  = 4'h8;
    localparam logic [4:0] OFFSET_POS_BIAS   = 5'h07;
    localparam logic [4:0] OFFSET_NEG_BIAS   = 5'h08;

    // ------------------------------------------------------------
    // Bit-counter reset value and byte length of the bus engine
    // ------------------------------------------------------------
    localparam logic [3:0] BITCNT_RESET      = 4'h0;
    localparam logic [3:0] BITS_PER_BYTE     = 4'h8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ACK_ADDR,
        BUS_CMD,
        BUS_ACK_CMD,
        BUS_WDATA,
        BUS_ACK_DATA,
        BUS_RDATA,
        BUS_RACK
    } bus_state_t;

    // Values restored from nonvolatile memory at supply reset
    typedef struct packed {
        logic       address_source_override;
        logic [6:0] bus_target_address;
        logic [3:0] vid_bus_address;
        logic [7:0] output_current_trim;
    } nvm_image_t;

    // Raw converter sample, 0.25 A per LSB
    typedef struct packed {
        logic       valid;
        logic [9:0] quarters;
    } current_sample_t;

    typedef struct packed {
        bus_state_t  st;
        logic        scl_prev;
        logic        sda_prev;
        logic [3:0]  bitcnt;
        logic [7:0]  shift;
        logic [7:0]  ptr;
        logic        rw;
        logic        master_ack;
        logic        sda_oe_n;
        logic        override;
        logic [6:0]  strap;
        logic [6:0]  active_addr;
        logic [6:0]  addr_field;
        logic [3:0]  vid_addr;
        logic [7:0]  trim;
        logic [7:0]  reading;
        logic        reading_valid;
    } state_t;

endpackage

// file: test/host_model.sv
// Two-wire bus host model: start, stop and byte transfers
module host_model (
    // Clock and wire level
    input  wire logic mclk,
    input  wire logic sda_line,
    // Host drives, 1 means released
    output      logic scl,
    output      logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic start();
        sda = 1'b1;
        hold(10);
        scl = 1'b1;
        hold(10);
        sda = 1'b0;
        hold(10);
        scl = 1'b0;
        hold(4);
    endtask
    task automatic stop();
        sda = 1'b0;
        hold(10);
        scl = 1'b1;
        hold(10);
        sda = 1'b1;
        hold(10);
    endtask
    // Data moves a few cycles after the clock fall so it never races the fall
    task automatic bit_io(input logic b, output logic r);
        sda = b;
        hold(10);
        scl = 1'b1;
        hold(5);
        r = sda_line;
        hold(5);
        scl = 1'b0;
        hold(4);
    endtask
    // The ninth bit is always released, so reads end with a NACK
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
endmodule // host_model

// file: test/trim_regs_properties.sv
// Port-level assertions for the trim register bank
module trim_regs_properties (
    // Clock and reset
    input wire logic                           mclk,
    input wire logic                           sys_rst,
    // Bus pins
    input wire logic                           scl_in,
    input wire logic                           sda_in,
    input wire logic                           sda_out,
    input wire logic                           sda_oe_n,
    // Power-up sources
    input wire logic [6:0]                     strap_address,
    input wire trim_regs_pkg::nvm_image_t      nvm_image,
    // Telemetry
    input wire trim_regs_pkg::current_sample_t current_monitor,
    input wire logic [7:0]                     full_scale_current_limit,
    input wire logic [7:0]                     output_current_reading,
    input wire logic                           output_current_valid,
    // Addresses in force
    input wire logic [6:0]                     bus_address_active,
    input wire logic [3:0]                     vid_bus_address
);
    timeunit 1ns;
    timeprecision 100ps;
    import trim_regs_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_sample; current_monitor.valid; endsequence
    sequence s_answer; ##1 output_current_valid; endsequence
    property p_valid_follows; s_sample |-> s_answer; endproperty
    property p_valid_cause; output_current_valid |-> $past(current_monitor.valid); endproperty
    property p_reading_hold; !output_current_valid |-> $stable(output_current_reading); endproperty
    property p_addr_load;
        $fell(sys_rst) |-> bus_address_active == ($past(nvm_image.address_source_override) ?
            $past(nvm_image.bus_target_address) : $past(strap_address));
    endproperty
    property p_addr_hold; !$past(sys_rst) |-> $stable(bus_address_active); endproperty
    property p_vid_load; $fell(sys_rst) |-> vid_bus_address == $past(nvm_image.vid_bus_address); endproperty
    property p_vid_legal; vid_bus_address <= VID_ADDR_LAST; endproperty
    // Writes land on a bus clock fall, so a change with the clock high is spurious
    property p_vid_on_bus; $changed(vid_bus_address) && !$past(sys_rst) |-> !scl_in; endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("reading valid missing");
    a_valid_cause: assert property (p_valid_cause) else $error("reading valid without sample");
    a_reading_hold: assert property (p_reading_hold) else $error("reading moved between samples");
    a_addr_load: assert property (p_addr_load) else $error("bus address wrong after reset");
    a_addr_hold: assert property (p_addr_hold) else $error("bus address moved without reset");
    a_vid_load: assert property (p_vid_load) else $error("vid address wrong after reset");
    a_vid_legal: assert property (p_vid_legal) else $error("vid address reserved code");
    a_vid_on_bus: assert property (p_vid_on_bus) else $error("vid address changed off bus");
endmodule // trim_regs_properties

bind trim_regs trim_regs_properties u_props (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_address(strap_address),
    .nvm_image(nvm_image), .current_monitor(current_monitor),
    .full_scale_current_limit(full_scale_current_limit), .output_current_reading(output_current_reading),
    .output_current_valid(output_current_valid), .bus_address_active(bus_address_active),
    .vid_bus_address(vid_bus_address));

// file: test/trim_regs_tb.sv
// Self-checking bench for the trim register bank
module trim_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import trim_regs_pkg::*;
    logic            mclk, sys_rst, scl, host_sda, sda_out, sda_oe_n, out_valid;
    logic [6:0]      strap, cur_addr, bus_active;
    logic [7:0]      reading, limit;
    logic [3:0]      vid;
    nvm_image_t      nvm;
    current_sample_t sample;
    int              mismatches, n_compared;
    wire logic       sda_line = host_sda & (sda_oe_n | sda_out);
    logic [7:0]      vid_wr[4] = '{8'hF5, 8'h0E, 8'h0F, 8'h0D};
    logic [7:0]      vid_exp[4] = '{8'h05, 8'h05, 8'h05, 8'h0D};
    // 74h and 70h break the zero-load offset advice on purpose to show the wrap; 8Fh keeps it
    logic [7:0]      trims[6] = '{8'h08, 8'hF8, 8'h7F, 8'h74, 8'h70, 8'h8F};
    logic [9:0]      raws[6] = '{10'h190, 10'h190, 10'h064, 10'h002, 10'h000, 10'h000};

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    host_model u_host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda(host_sda));
    trim_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .strap_address(strap), .nvm_image(nvm), .current_monitor(sample),
        .full_scale_current_limit(limit), .output_current_reading(reading),
        .output_current_valid(out_valid), .bus_address_active(bus_active), .vid_bus_address(vid));

    // ------------------------------------------------------------
    // Access and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reset_dut(input nvm_image_t img);
        nvm = img;
        sys_rst = 1'b1;
        repeat (5) @(posedge mclk);
        #1 sys_rst = 1'b0;
        repeat (6) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
        logic [7:0] rx;
        logic       k0, k1, k2;
        u_host.start();
        u_host.xfer({a, 1'b0}, rx, k0);
        u_host.xfer(c, rx, k1);
        u_host.xfer(d, rx, k2);
        u_host.stop();
        chk({5'h00, k0, k1, k2}, (a == cur_addr) ? 8'h07 : 8'h00);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic [7:0] exp);
        logic [7:0] rx;
        logic       k0, k1, k2, k3;
        u_host.start();
        u_host.xfer({a, 1'b0}, rx, k0);
        u_host.xfer(c, rx, k1);
        u_host.start();
        u_host.xfer({a, 1'b1}, rx, k2);
        u_host.xfer(8'hFF, rx, k3);
        u_host.stop();
        chk({5'h00, k0, k1, k2}, 8'h07);
        chk(rx, exp);
    endtask
    // Expected reading: gain then offset in quarter amps, wrapped below the limit
    task automatic sample_chk(input logic [7:0] trim, input logic [9:0] raw);
        int s;
        s = int'(raw) * (193 + int'(trim[7:4])) / 200;
        s += (trim[3:0] >= 4'h8) ? int'(trim[3:0]) - 7 : int'(trim[3:0]) - 8;
        if (s < 0) s += 4 * int'(limit);
        wr(cur_addr, OUTPUT_CURRENT_TRIM_OFS, trim);
        sample = '{1'b1, raw};
        @(posedge mclk);
        #1 sample.valid = 1'b0;
        chk({7'h00, out_valid}, 8'h01);
        chk(reading, s[9:2]);
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        print_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        strap = 7'h24;
        cur_addr = 7'h24;
        limit = 8'h1E;
        sample = '0;
        nvm = '0;
        reset_dut('{1'b0, 7'h31, 4'h3, 8'h78});
        chk({1'b0, bus_active}, 8'h24);
        chk({4'h0, vid}, 8'h03);
        rd(7'h24, BUS_TARGET_ADDRESS_OFS, 8'h24);
        rd(7'h24, OUTPUT_CURRENT_TRIM_OFS, 8'h78);
        wr(7'h24, BUS_TARGET_ADDRESS_OFS, 8'hFF);
        rd(7'h24, BUS_TARGET_ADDRESS_OFS, 8'h24);
        wr(7'h31, VID_BUS_ADDRESS_OFS, 8'h01);
        chk({1'b0, bus_active}, 8'h24);
        foreach (vid_wr[i]) begin
            wr(7'h24, VID_BUS_ADDRESS_OFS, vid_wr[i]);
            chk({4'h0, vid}, vid_exp[i]);
        end
        rd(7'h24, VID_BUS_ADDRESS_OFS, 8'h0D);
        rd(7'h24, 8'hA9, UNMAPPED_READ);
        foreach (trims[i]) sample_chk(trims[i], raws[i]);
        rd(7'h24, OUTPUT_CURRENT_TRIM_OFS, 8'h8F);
        // Address stored with override set, then supply reset
        cur_addr = 7'h31;
        reset_dut('{1'b1, 7'h31, 4'hD, 8'h12});
        chk({1'b0, bus_active}, 8'h31);
        rd(7'h31, BUS_TARGET_ADDRESS_OFS, 8'h31);
        wr(7'h31, BUS_TARGET_ADDRESS_OFS, 8'hD5);
        rd(7'h31, BUS_TARGET_ADDRESS_OFS, 8'h55);
        chk({1'b0, bus_active}, 8'h31);
        wr(7'h24, OUTPUT_CURRENT_TRIM_OFS, 8'h00);
        rd(7'h31, OUTPUT_CURRENT_TRIM_OFS, 8'h12);
        print_verdict();
    end
endmodule // trim_regs_tb
